/* inc/haptic_pkg.sv */
package haptic_pkg;
	// Clock and step timing.
	localparam int CLK_PERIOD_NS = 20;
	localparam int STEP_UNIT_NS = 1360000;
	localparam int STEP_UNIT_CYC = STEP_UNIT_NS / CLK_PERIOD_NS;
	// Step duration multiples of the 1.36 ms unit.
	localparam logic [6:0] MULT_1 = 7'h01;
	localparam logic [6:0] MULT_4 = 7'h04;
	localparam logic [6:0] MULT_16 = 7'h10;
	localparam logic [6:0] MULT_32 = 7'h20;
	localparam logic [6:0] MULT_64 = 7'h40;
	localparam int STEP_CNT_W = 24;
	// Frame byte fields.
	localparam int TYPE_BIT = 7;
	localparam int GAIN_MSB = 6;
	localparam int GAIN_LSB = 5;
	localparam int TB_MSB = 4;
	localparam int TB_LSB = 3;
	localparam int IDL_MSB = 2;
	localparam int IDL_LSB = 0;
	localparam int LOOP_MSB = 6;
	localparam int LOOP_LSB = 3;
	localparam int DRIVE_FREQUENCY_CODE_FLAG_BIT = 2;
	localparam int DRIVE_FREQUENCY_CODE_MSB_BIT = 1;
	localparam int IDH_BIT = 0;
	// Frequency and period.
	localparam logic [9:0] DRIVE_FREQUENCY_CODE_MIN_HZ = 10'h019;
	localparam logic [9:0] DRIVE_FREQUENCY_CODE_RESET_HZ = 10'h0C8;
	localparam logic [19:0] PERIOD_NUM_US = 20'hF4240;
	// Drive scaling.
	localparam logic [7:0] DRIVE_FULL = 8'h7F;
	localparam logic [7:0] DRIVE_NEG_MAX = 8'h80;
	localparam logic [7:0] DRIVE_NEG_FULL = 8'h81;
	localparam logic [7:0] PWM_MID = 8'h80;
	localparam logic [3:0] AMP_NEG_MAX = 4'h8;
	localparam logic [11:0] AMP_SIGNED_FULL = 12'h007;
	localparam logic [11:0] AMP_UNSIGNED_FULL = 12'h00F;
	localparam logic [7:0] POINT_FIRST = 8'h00;
	localparam logic [7:0] POINT_REPEAT = 8'h01;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_BYTE1,
		ST_BYTE2,
		ST_BYTE3,
		ST_FETCH,
		ST_PUSH,
		ST_HOLD,
		ST_END
	} play_state_e;
endpackage

/* inc/drive_stream_if.sv */
`timescale 1ns/1ns
interface drive_stream_if;
	logic [7:0] data;
	logic valid;
	logic ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface // drive_stream_if

/* logic/drive_skid_buffer.sv */
`timescale 1ns/1ns
module drive_skid_buffer (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	drive_stream_if.snk s_in,
	output logic [7:0] o_data,
	output logic o_valid,
	input wire logic i_ready
);
	logic [7:0] head_r;
	logic [7:0] tail_r;
	logic [1:0] count_r;
	logic push;
	logic pop;

	assign s_in.ready = (count_r != 2'h2);
	assign o_valid = (count_r != 2'h0);
	assign o_data = head_r;
	assign push = s_in.valid && s_in.ready;
	assign pop = o_valid && i_ready;

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			head_r <= 8'h00;
			tail_r <= 8'h00;
			count_r <= 2'h0;
		end else begin
			if (push && !pop) begin
				if (count_r == 2'h0) begin
					head_r <= s_in.data;
				end else begin
					tail_r <= s_in.data;
				end
				count_r <= count_r + 2'h1;
			end else if (pop && !push) begin
				head_r <= tail_r;
				count_r <= count_r - 2'h1;
			end else if (pop && push) begin
				if (count_r == 2'h1) begin
					head_r <= s_in.data;
				end else begin
					head_r <= tail_r;
					tail_r <= s_in.data;
				end
			end
		end
	end
endmodule // drive_skid_buffer

/* logic/haptic_frame_player.sv */
`timescale 1ns/1ns
// Notes on behaviour
// [R1] First byte bits 2:0 give snippet index low.
// [R2] Second byte bit 0 is index MSB, else zero.
// [R3] Play snippet repeat count plus one times.
// [R4] Repeats after the first restart at point one.
// [R5] Frequency flag makes frame three bytes long.
// [R6] Nine-bit frequency code, two hertz per step.
// [R7] Frequencies below 25 Hz become 25 Hz.
// [R8] Frequency converted to period for readback.
// [R9] Commanded frequency persists until next frequency frame.
// [R10] Software sends frequency only with tracking off.
// [R11] Only whole sequences can be started.
// [R12] Sequence end drives zero and stops playback.
// [R13] Sequence starts at zero; frames continue levels.
// [R14] Envelope points are four-bit values.
// [R15] Host byte signed, -128 read as -127.
// [R16] Acceleration mode turns negative host bytes zero.
// [R17] PWM 0/50/100 percent gives -full/zero/+full.
// [R18] Accelerated PWM 0/50/100 gives zero/half/full.
// [R19] PWM drive below threshold is forced zero.
// [R20] PWM value stored in direct drive readback.
// [R21] Unaccelerated amplitudes signed, -8 read as -7.
// [R22] Accelerated amplitudes unsigned, never negative.
// [R23] Top bit tells first byte from second byte.
// [R24] Attenuation 0, -6, -12, -18 dB applied.
// [R25] Step duration table depends on fast timebase.
module haptic_frame_player #(
	parameter int STEP_UNIT_CYCLES = haptic_pkg::STEP_UNIT_CYC
) (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic i_accel_en,
	input wire logic i_host_stream_mode,
	input wire logic i_pwm_mode,
	input wire logic i_register_triggered_memory_mode,
	input wire logic i_edge_triggered_memory_mode,
	input wire logic i_resonance_tracking_enable,
	input wire logic i_fast_timebase_select,
	input wire logic [7:0] i_zero_drive_threshold,
	input wire logic [7:0] i_host_drive_byte,
	input wire logic i_host_drive_valid,
	output logic o_host_drive_ready,
	input wire logic [7:0] i_pwm_duty,
	input wire logic i_pwm_valid,
	output logic o_pwm_ready,
	input wire logic i_seq_start,
	input wire logic [7:0] i_frame_byte,
	input wire logic i_frame_valid,
	input wire logic i_frame_last,
	output logic o_frame_ready,
	output logic o_point_req,
	output logic [3:0] o_point_snippet,
	output logic [7:0] o_point_index,
	input wire logic i_point_valid,
	input wire logic [3:0] i_point_amp,
	input wire logic i_point_last,
	output logic o_playing,
	output logic o_mem_fault,
	output logic [9:0] o_drive_drive_frequency_code_hz,
	output logic [19:0] o_active_period_readback,
	output logic [7:0] o_direct_drive_value,
	output logic [7:0] o_drive_value,
	output logic o_drive_valid,
	input wire logic i_drive_ready
);
	haptic_pkg::play_state_e state_r;
	logic [1:0] gain_r;
	logic [1:0] timebase_r;
	logic [3:0] snippet_r;
	logic [3:0] loops_left_r;
	logic seq_last_r;
	logic [7:0] amp_r;
	logic [7:0] point_r;
	logic point_last_r;
	logic [haptic_pkg::STEP_CNT_W-1:0] step_cnt_r;
	logic [8:0] drive_frequency_code_r;
	logic drive_frequency_code_new_r;
	logic [7:0] direct_drive_r;
	logic fault_r;
	logic [9:0] drive_frequency_code_hz;
	logic mem_busy;
	logic host_take;
	logic pwm_take;
	logic frame_take;
	logic [7:0] pwm_value;
	drive_stream_if drv ();

	function automatic logic [7:0] host_to_drive(input logic [7:0] b,
			input logic accel);
		logic [7:0] v;
		v = b;
		if (accel) begin
			if (b[7]) begin
				v = 8'h00; // [R16]
			end
		end else if (b == haptic_pkg::DRIVE_NEG_MAX) begin
			v = haptic_pkg::DRIVE_NEG_FULL; // [R15]
		end
		return v;
	endfunction

	function automatic logic [7:0] pwm_to_drive(input logic [7:0] d,
			input logic accel, input logic [7:0] thr);
		logic [7:0] v;
		logic [7:0] mag;
		v = 8'h00;
		mag = 8'h00;
		if (accel) begin
			v = {1'b0, d[7:1]}; // [R18]
		end else begin
			v = host_to_drive(d ^ haptic_pkg::PWM_MID, 1'b0); // [R17]
		end
		mag = v[7] ? 8'((~v) + 8'h01) : v;
		if (mag < thr) begin
			v = 8'h00; // [R19]
		end
		return v;
	endfunction

	function automatic logic [7:0] amp_to_drive(input logic [3:0] a,
			input logic accel);
		logic [3:0] s;
		logic [3:0] m;
		logic [11:0] p;
		logic [7:0] v;
		s = a;
		m = 4'h0;
		p = 12'h000;
		v = 8'h00;
		if (accel) begin
			// Unsigned envelope scaled so 15 is full drive.
			p = 12'(({8'h00, a} * 12'(haptic_pkg::DRIVE_FULL))
				/ haptic_pkg::AMP_UNSIGNED_FULL); // [R22]
			v = p[7:0];
		end else begin
			if (a == haptic_pkg::AMP_NEG_MAX) begin
				s = 4'h9; // [R21]
			end
			m = s[3] ? 4'((~s) + 4'h1) : s;
			p = 12'(({8'h00, m} * 12'(haptic_pkg::DRIVE_FULL))
				/ haptic_pkg::AMP_SIGNED_FULL); // [R21]
			v = s[3] ? 8'((~p[7:0]) + 8'h01) : p[7:0];
		end
		return v;
	endfunction

	function automatic logic [haptic_pkg::STEP_CNT_W-1:0] step_cycles(
			input logic [1:0] tb, input logic fast);
		logic [6:0] mult;
		mult = haptic_pkg::MULT_1;
		case (tb)
			2'h0: mult = fast ? haptic_pkg::MULT_1 : haptic_pkg::MULT_4;
			2'h1: mult = fast ? haptic_pkg::MULT_4 : haptic_pkg::MULT_16;
			2'h2: mult = fast ? haptic_pkg::MULT_16 : haptic_pkg::MULT_32;
			default: mult = fast ? haptic_pkg::MULT_32 : haptic_pkg::MULT_64;
		endcase // [R25]
		return haptic_pkg::STEP_CNT_W'(STEP_UNIT_CYCLES * int'(mult));
	endfunction

	assign mem_busy = (state_r != haptic_pkg::ST_IDLE);
	assign o_playing = mem_busy;
	assign o_mem_fault = fault_r;
	assign o_point_req = (state_r == haptic_pkg::ST_FETCH);
	assign o_point_snippet = snippet_r;
	assign o_point_index = point_r;
	assign o_direct_drive_value = direct_drive_r;
	assign pwm_value = pwm_to_drive(i_pwm_duty, i_accel_en,
		i_zero_drive_threshold);

	// A second byte is only consumed when its type bit marks it as one;
	// otherwise it is the next frame's first byte and stays in the stream.
	always_comb begin
		o_frame_ready = 1'b0;
		case (state_r)
			haptic_pkg::ST_BYTE1: o_frame_ready = 1'b1;
			haptic_pkg::ST_BYTE2:
				o_frame_ready = i_frame_byte[haptic_pkg::TYPE_BIT]; // [R23]
			haptic_pkg::ST_BYTE3: o_frame_ready = 1'b1;
			default: o_frame_ready = 1'b0;
		endcase
	end
	assign frame_take = i_frame_valid && o_frame_ready;

	// Memory playback owns the drive path; host and PWM wait meanwhile.
	always_comb begin
		drv.valid = 1'b0;
		drv.data = 8'h00;
		if (state_r == haptic_pkg::ST_PUSH) begin
			drv.valid = 1'b1;
			drv.data = 8'(signed'(amp_r) >>> gain_r); // [R24]
		end else if (state_r == haptic_pkg::ST_END) begin
			drv.valid = 1'b1;
			drv.data = 8'h00; // [R12]
		end else if (!mem_busy && i_host_stream_mode) begin
			drv.valid = i_host_drive_valid;
			drv.data = host_to_drive(i_host_drive_byte, i_accel_en);
		end else if (!mem_busy && i_pwm_mode) begin
			drv.valid = i_pwm_valid;
			drv.data = pwm_value;
		end
	end
	assign o_host_drive_ready = !mem_busy && i_host_stream_mode && drv.ready;
	assign o_pwm_ready = !mem_busy && !i_host_stream_mode && i_pwm_mode
		&& drv.ready;
	assign host_take = o_host_drive_ready && i_host_drive_valid;
	assign pwm_take = o_pwm_ready && i_pwm_valid;

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			direct_drive_r <= 8'h00;
		end else if (host_take) begin
			direct_drive_r <= i_host_drive_byte;
		end else if (pwm_take) begin
			direct_drive_r <= pwm_value; // [R20]
		end
	end

	// The frequency is kept across frames and sequences; tracking, when
	// enabled elsewhere, is expected to be left off by software.
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			drive_frequency_code_r <= 9'h000;
			drive_frequency_code_new_r <= 1'b0;
		end else if (state_r == haptic_pkg::ST_BYTE3 && frame_take) begin
			drive_frequency_code_r[7:0] <= i_frame_byte; // [R5] [R9]
			drive_frequency_code_new_r <= 1'b1;
		end else if (state_r == haptic_pkg::ST_BYTE2 && frame_take
				&& i_frame_byte[haptic_pkg::DRIVE_FREQUENCY_CODE_FLAG_BIT]
				&& !i_frame_last) begin
			// Frames without a frequency command must leave the code alone.
			drive_frequency_code_r[8] <=
				i_frame_byte[haptic_pkg::DRIVE_FREQUENCY_CODE_MSB_BIT]; // [R6] [R9]
		end else if (state_r == haptic_pkg::ST_FETCH
				&& point_r == haptic_pkg::POINT_FIRST) begin
			drive_frequency_code_new_r <= 1'b0;
		end
	end

	always_comb begin
		drive_frequency_code_hz = {drive_frequency_code_r, 1'b0}; // [R6]
		if (drive_frequency_code_hz < haptic_pkg::DRIVE_FREQUENCY_CODE_MIN_HZ) begin
			drive_frequency_code_hz = haptic_pkg::DRIVE_FREQUENCY_CODE_MIN_HZ; // [R7]
		end
	end

	// The period is held until a frequency frame completes, so a
	// half-loaded code never reaches the readback.
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_drive_drive_frequency_code_hz <= haptic_pkg::DRIVE_FREQUENCY_CODE_RESET_HZ;
			o_active_period_readback <= 20'h00000;
		end else if (state_r == haptic_pkg::ST_FETCH && drive_frequency_code_new_r
				&& point_r == haptic_pkg::POINT_FIRST) begin
			o_drive_drive_frequency_code_hz <= drive_frequency_code_hz; // [R9]
			o_active_period_readback <= 20'(haptic_pkg::PERIOD_NUM_US
				/ {10'h000, drive_frequency_code_hz}); // [R8]
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			fault_r <= 1'b0;
		end else begin
			fault_r <= (state_r == haptic_pkg::ST_BYTE1) && frame_take
				&& i_frame_byte[haptic_pkg::TYPE_BIT]; // [R23]
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_r <= haptic_pkg::ST_IDLE;
			gain_r <= 2'h0;
			timebase_r <= 2'h0;
			snippet_r <= 4'h0;
			loops_left_r <= 4'h0;
			seq_last_r <= 1'b0;
			amp_r <= 8'h00;
			point_r <= 8'h00;
			point_last_r <= 1'b0;
			step_cnt_r <= '0;
		end else begin
			case (state_r)
				haptic_pkg::ST_IDLE: begin
					// Only a sequence start enters playback.
					if (i_seq_start && (i_register_triggered_memory_mode
							|| i_edge_triggered_memory_mode)) begin
						amp_r <= 8'h00; // [R11] [R13]
						state_r <= haptic_pkg::ST_BYTE1;
					end
				end
				haptic_pkg::ST_BYTE1: begin
					if (frame_take) begin
						if (i_frame_byte[haptic_pkg::TYPE_BIT]) begin
							state_r <= haptic_pkg::ST_END; // [R23]
						end else begin
							gain_r <= i_frame_byte[haptic_pkg::GAIN_MSB:
								haptic_pkg::GAIN_LSB];
							timebase_r <= i_frame_byte[haptic_pkg::TB_MSB:
								haptic_pkg::TB_LSB];
							snippet_r <= {1'b0, i_frame_byte[
								haptic_pkg::IDL_MSB:haptic_pkg::IDL_LSB]};
							loops_left_r <= 4'h0; // [R1] [R2] [R3]
							seq_last_r <= i_frame_last;
							point_r <= haptic_pkg::POINT_FIRST;
							state_r <= i_frame_last ? haptic_pkg::ST_FETCH
								: haptic_pkg::ST_BYTE2;
						end
					end
				end
				haptic_pkg::ST_BYTE2: begin
					if (i_frame_valid) begin
						state_r <= haptic_pkg::ST_FETCH;
						if (frame_take) begin
							snippet_r[3] <=
								i_frame_byte[haptic_pkg::IDH_BIT]; // [R2]
							loops_left_r <= i_frame_byte[
								haptic_pkg::LOOP_MSB:
								haptic_pkg::LOOP_LSB]; // [R3]
							seq_last_r <= i_frame_last;
							if (i_frame_byte[haptic_pkg::DRIVE_FREQUENCY_CODE_FLAG_BIT]
									&& !i_frame_last) begin
								state_r <= haptic_pkg::ST_BYTE3; // [R5]
							end
						end
					end
				end
				haptic_pkg::ST_BYTE3: begin
					if (frame_take) begin
						seq_last_r <= i_frame_last;
						state_r <= haptic_pkg::ST_FETCH;
					end
				end
				haptic_pkg::ST_FETCH: begin
					if (i_point_valid) begin
						amp_r <= amp_to_drive(i_point_amp, i_accel_en); // [R14]
						point_last_r <= i_point_last;
						state_r <= haptic_pkg::ST_PUSH;
					end
				end
				haptic_pkg::ST_PUSH: begin
					if (drv.ready) begin
						step_cnt_r <= step_cycles(timebase_r,
							i_fast_timebase_select); // [R25]
						state_r <= haptic_pkg::ST_HOLD;
					end
				end
				haptic_pkg::ST_HOLD: begin
					if (step_cnt_r > haptic_pkg::STEP_CNT_W'(1)) begin
						step_cnt_r <= step_cnt_r - haptic_pkg::STEP_CNT_W'(1);
					end else if (!point_last_r) begin
						point_r <= point_r + 8'h01;
						state_r <= haptic_pkg::ST_FETCH;
					end else if (loops_left_r != 4'h0) begin
						loops_left_r <= loops_left_r - 4'h1; // [R3]
						point_r <= haptic_pkg::POINT_REPEAT; // [R4]
						state_r <= haptic_pkg::ST_FETCH;
					end else if (seq_last_r) begin
						state_r <= haptic_pkg::ST_END; // [R12]
					end else begin
						// Next frame starts from the level now held. [R13]
						state_r <= haptic_pkg::ST_BYTE1;
					end
				end
				haptic_pkg::ST_END: begin
					if (drv.ready) begin
						amp_r <= 8'h00;
						state_r <= haptic_pkg::ST_IDLE; // [R12]
					end
				end
				default: state_r <= haptic_pkg::ST_IDLE;
			endcase
		end
	end

	drive_skid_buffer u_buf (
		.i_ref_clk(i_ref_clk),
		.i_rstn(i_rstn),
		.s_in(drv.snk),
		.o_data(o_drive_value),
		.o_valid(o_drive_valid),
		.i_ready(i_drive_ready)
	);
endmodule // haptic_frame_player

/* dv/haptic_frame_player_asserts.sv */
`timescale 1ns/1ns
module haptic_frame_player_asserts #(
	parameter int STEP_UNIT_CYCLES = 4
) (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic i_accel_en,
	input wire logic [7:0] i_zero_drive_threshold,
	input wire logic [7:0] i_host_drive_byte,
	input wire logic i_host_drive_valid,
	input wire logic o_host_drive_ready,
	input wire logic [7:0] i_pwm_duty,
	input wire logic i_pwm_valid,
	input wire logic o_pwm_ready,
	input wire logic [7:0] i_frame_byte,
	input wire logic i_frame_valid,
	input wire logic o_frame_ready,
	input wire logic o_playing,
	input wire logic o_mem_fault,
	input wire logic [9:0] o_drive_drive_frequency_code_hz,
	input wire logic [19:0] o_active_period_readback,
	input wire logic [7:0] o_direct_drive_value,
	input wire logic [7:0] o_drive_value,
	input wire logic o_drive_valid
);
	logic [7:0] pwm_val;
	logic [7:0] pwm_mag;
	assign pwm_val = i_pwm_duty ^ 8'h80;
	assign pwm_mag = pwm_val[7] ? 8'h00 - pwm_val : pwm_val;
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rstn);
	// A push into an empty buffer shows at the output one cycle later.
	sequence host_take;
		i_host_drive_valid && o_host_drive_ready && !o_drive_valid;
	endsequence
	sequence pwm_take;
		i_pwm_valid && o_pwm_ready && !o_drive_valid;
	endsequence
	a_ready_while_play: assert property (
		o_playing |-> !o_host_drive_ready && !o_pwm_ready)
		else $error("Stream ready during playback.");
	a_host_signed: assert property (
		host_take ##0 !i_accel_en |=> o_drive_value == ($past(
		i_host_drive_byte) == 8'h80 ? 8'h81 : $past(i_host_drive_byte)))
		else $error("Host byte mapped wrongly.");
	a_host_accel_neg: assert property (
		host_take ##0 (i_accel_en && i_host_drive_byte[7])
		|=> o_drive_value == 8'h00) else $error("Negative host byte kept.");
	a_pwm_readback: assert property (
		(i_pwm_valid && o_pwm_ready && !i_accel_en &&
		i_zero_drive_threshold == 8'h00) |=> o_direct_drive_value ==
		($past(pwm_val) == 8'h80 ? 8'h81 : $past(pwm_val)))
		else $error("PWM readback wrong.");
	a_pwm_accel_pos: assert property (
		(i_pwm_valid && o_pwm_ready && i_accel_en)
		|=> !o_direct_drive_value[7]) else $error("Negative PWM drive.");
	a_pwm_thresh: assert property (
		pwm_take ##0 (!i_accel_en && pwm_mag < i_zero_drive_threshold)
		|=> o_drive_value == 8'h00) else $error("Weak PWM not zeroed.");
	a_fault_pulse: assert property (
		o_mem_fault |-> $past(i_frame_valid && o_frame_ready &&
		i_frame_byte[7]) ##1 !o_mem_fault) else $error("Bad fault pulse.");
	a_drive_frequency_code_legal: assert property (
		o_drive_drive_frequency_code_hz >= haptic_pkg::DRIVE_FREQUENCY_CODE_MIN_HZ &&
		(o_drive_drive_frequency_code_hz == haptic_pkg::DRIVE_FREQUENCY_CODE_MIN_HZ || !o_drive_drive_frequency_code_hz[0]))
		else $error("Illegal drive frequency.");
	a_period_match: assert property (
		$changed(o_drive_drive_frequency_code_hz) |-> ##[0:2] (o_active_period_readback ==
		haptic_pkg::PERIOD_NUM_US / o_drive_drive_frequency_code_hz))
		else $error("Period readback wrong.");
endmodule // haptic_frame_player_asserts

bind haptic_frame_player haptic_frame_player_asserts #(
	.STEP_UNIT_CYCLES(STEP_UNIT_CYCLES)
) haptic_frame_player_asserts_inst (
	.i_ref_clk, .i_rstn, .i_accel_en, .i_zero_drive_threshold,
	.i_host_drive_byte, .i_host_drive_valid, .o_host_drive_ready,
	.i_pwm_duty, .i_pwm_valid, .o_pwm_ready, .i_frame_byte,
	.i_frame_valid, .o_frame_ready, .o_playing, .o_mem_fault,
	.o_drive_drive_frequency_code_hz, .o_active_period_readback, .o_direct_drive_value,
	.o_drive_value, .o_drive_valid
);

/* dv/point_memory_model.sv */
`timescale 1ns/1ns
module point_memory_model (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic i_req,
	input wire logic [7:0] i_index,
	input wire logic [3:0] i_lat,
	output logic o_valid,
	output logic [3:0] o_amp,
	output logic o_last
);
	logic [3:0] cnt_r;
	logic [3:0] amp;
	// Every snippet holds the same three points to keep expectations short.
	always_comb begin
		case (i_index)
			8'h00: amp = 4'h7;
			8'h01: amp = 4'h8;
			default: amp = 4'h3;
		endcase
	end
	// Between answers the lines show the inverse, never a stale point.
	assign o_amp = o_valid ? amp : ~amp;
	assign o_last = o_valid ? (i_index == 8'h02) : (i_index != 8'h02);
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_r <= 4'h0;
			o_valid <= 1'b0;
		end else if (!i_req || o_valid) begin
			cnt_r <= 4'h0;
			o_valid <= 1'b0;
		end else if (cnt_r == i_lat) begin
			o_valid <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 4'h1;
		end
	end
endmodule // point_memory_model

/* dv/haptic_frame_player_tb_top.sv */
`timescale 1ns/1ns
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
	fail_count++; $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module haptic_frame_player_tb_top;
	logic i_ref_clk, i_rstn, i_accel_en, i_host_stream_mode, i_pwm_mode;
	logic i_register_triggered_memory_mode, i_edge_triggered_memory_mode;
	logic i_resonance_tracking_enable, i_fast_timebase_select, i_seq_start;
	logic i_host_drive_valid, i_pwm_valid, i_frame_valid, i_frame_last;
	logic i_point_valid, i_point_last, i_drive_ready, o_host_drive_ready;
	logic o_pwm_ready, o_frame_ready, o_point_req, o_playing, o_mem_fault;
	logic o_drive_valid, fault_seen;
	logic [7:0] i_zero_drive_threshold, i_host_drive_byte, i_pwm_duty;
	logic [7:0] i_frame_byte, o_point_index, o_direct_drive_value;
	logic [7:0] o_drive_value;
	logic [3:0] i_point_amp, o_point_snippet, lat;
	logic [9:0] o_drive_drive_frequency_code_hz;
	logic [19:0] o_active_period_readback;
	logic [7:0] got[$];
	logic [7:0] pts[$];
	logic [31:0] pwm_tab [7] = '{32'h00000081, 32'h80000000, 32'hFF00007F,
		32'h88001000, 32'h98001018, 32'h00010000, 32'hFF01007F};
	int fail_count, comparisons, cycles;
	int pop_t[$];
	haptic_frame_player #(.STEP_UNIT_CYCLES(4)) haptic_frame_player_inst (
		.i_ref_clk, .i_rstn, .i_accel_en, .i_host_stream_mode, .i_pwm_mode,
		.i_register_triggered_memory_mode, .i_edge_triggered_memory_mode,
		.i_resonance_tracking_enable, .i_fast_timebase_select,
		.i_zero_drive_threshold, .i_host_drive_byte, .i_host_drive_valid,
		.o_host_drive_ready, .i_pwm_duty, .i_pwm_valid, .o_pwm_ready,
		.i_seq_start, .i_frame_byte, .i_frame_valid, .i_frame_last,
		.o_frame_ready, .o_point_req, .o_point_snippet, .o_point_index,
		.i_point_valid, .i_point_amp, .i_point_last, .o_playing, .o_mem_fault,
		.o_drive_drive_frequency_code_hz, .o_active_period_readback, .o_direct_drive_value,
		.o_drive_value, .o_drive_valid, .i_drive_ready);
	point_memory_model point_memory_model_inst (.i_ref_clk, .i_rstn,
		.i_req(o_point_req), .i_index(o_point_index), .i_lat(lat),
		.o_valid(i_point_valid), .o_amp(i_point_amp), .o_last(i_point_last));
	initial begin
		i_ref_clk = 1'b0;
		forever #10 i_ref_clk = ~i_ref_clk;
	end
	always @(posedge i_ref_clk) begin
		if (o_drive_valid && i_drive_ready) begin
			got.push_back(o_drive_value);
			pop_t.push_back(cycles);
		end
		if (o_point_req && i_point_valid)
			pts.push_back({o_point_snippet, o_point_index[3:0]});
		if (o_mem_fault) fault_seen = 1'b1;
		cycles++;
		if (cycles == 60000) begin
			fail_count++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic push(input int src, input logic [7:0] b, input logic last);
		int n;
		@(posedge i_ref_clk);
		{i_host_drive_byte, i_pwm_duty, i_frame_byte} <= {b, b, b};
		i_frame_last <= last;
		{i_host_drive_valid, i_pwm_valid} <= {src == 0, src == 1};
		i_frame_valid <= src == 2;
		for (n = 0; n < 2000; n++) begin
			@(negedge i_ref_clk);
			if ((src == 0 ? o_host_drive_ready : src == 1 ? o_pwm_ready :
				o_frame_ready) === 1'b1) break;
		end
		`CHK("handshake", 1'b1, n < 2000)
		@(posedge i_ref_clk);
		{i_host_drive_valid, i_pwm_valid, i_frame_valid} <= 3'h0;
	endtask
	task automatic cmpq(input string w, ref logic [7:0] q[$],
		input logic [7:0] e[$]);
		for (int n = 0; n < 3000 && q.size() < e.size(); n++)
			@(posedge i_ref_clk);
		`CHK(w, e.size(), q.size())
		if (q.size() == e.size()) foreach (e[k]) `CHK(w, e[k], q[k])
		q.delete();
	endtask
	task automatic play(input logic [7:0] b[$]);
		@(posedge i_ref_clk);
		i_seq_start <= 1'b1;
		@(posedge i_ref_clk);
		i_seq_start <= 1'b0;
		foreach (b[k]) push(2, b[k], k == b.size() - 1);
	endtask
	initial begin
		// Tracking stays off so frequency frames are legal.
		{i_rstn, i_accel_en, i_host_stream_mode, i_pwm_mode, i_seq_start,
			i_register_triggered_memory_mode, i_edge_triggered_memory_mode,
			i_resonance_tracking_enable, i_fast_timebase_select, lat,
			i_host_drive_valid, i_pwm_valid, i_frame_valid, i_frame_last,
			i_drive_ready, i_zero_drive_threshold, i_host_drive_byte,
			i_pwm_duty, i_frame_byte, fault_seen} = '0;
		repeat (2) @(posedge i_ref_clk);
		i_rstn <= 1'b1;
		i_host_stream_mode <= 1'b1;
		push(0, 8'h80, 1'b0);
		push(0, 8'h7F, 1'b0);
		@(negedge i_ref_clk);
		`CHK("host ready when full", 1'b0, o_host_drive_ready)
		@(posedge i_ref_clk);
		{i_drive_ready, i_accel_en} <= 2'h3;
		// Let the buffer drain so the negative byte shows on its own.
		repeat (3) @(posedge i_ref_clk);
		push(0, 8'hFF, 1'b0);
		push(0, 8'h40, 1'b0);
		cmpq("host words", got, '{8'h81, 8'h7F, 8'h00, 8'h40});
		{i_host_stream_mode, i_pwm_mode} <= 2'h1;
		foreach (pwm_tab[k]) begin
			@(posedge i_ref_clk);
			i_accel_en <= pwm_tab[k][16];
			i_zero_drive_threshold <= pwm_tab[k][15:8];
			push(1, pwm_tab[k][31:24], 1'b0);
			cmpq("pwm word", got, '{pwm_tab[k][7:0]});
		end
		push(1, 8'h80, 1'b0);
		repeat (4) @(posedge i_ref_clk);
		`CHK("pwm half", 1'b1, got[0] == 8'h3F || got[0] == 8'h40)
		got.delete();
		{i_pwm_mode, i_register_triggered_memory_mode} <= 2'h1;
		{i_accel_en, i_fast_timebase_select} <= 2'h1;
		play('{8'h05, 8'h8F, 8'h00, 8'h22});
		cmpq("seq a words", got, '{8'h7F, 8'h81, 8'h36, 8'h81, 8'h36,
			8'h3F, 8'hC0, 8'h1B, 8'h00});
		cmpq("seq a points", pts, '{8'hD0, 8'hD1, 8'hD2, 8'hD1, 8'hD2,
			8'h20, 8'h21, 8'h22});
		repeat (2) @(posedge i_ref_clk);
		`CHK("drive_frequency_code a", 10'h200, o_drive_drive_frequency_code_hz)
		`CHK("period a", 20'h007A1, o_active_period_readback)
		`CHK("playing a", 1'b0, o_playing)
		{i_register_triggered_memory_mode, i_edge_triggered_memory_mode} <= 2'h1;
		{i_accel_en, i_fast_timebase_select, lat} <= {2'h2, 4'h5};
		pop_t.delete();
		play('{8'h01, 8'h80});
		cmpq("seq b words", got, '{8'h3B, 8'h43, 8'h19, 8'h00});
		cmpq("seq b points", pts, '{8'h10, 8'h11, 8'h12});
		`CHK("step b", 24, pop_t[1] - pop_t[0])
		`CHK("drive_frequency_code kept", 10'h200, o_drive_drive_frequency_code_hz)
		{i_accel_en, i_fast_timebase_select} <= 2'h1;
		pop_t.delete();
		play('{8'h78, 8'h84, 8'h05});
		cmpq("seq c words", got, '{8'h0F, 8'hF0, 8'h06, 8'h00});
		`CHK("step c", 136, pop_t[1] - pop_t[0])
		repeat (2) @(posedge i_ref_clk);
		`CHK("drive_frequency_code clamp", 10'h019, o_drive_drive_frequency_code_hz)
		`CHK("period c", 20'h09C40, o_active_period_readback)
		`CHK("no fault", 1'b0, fault_seen)
		play('{8'h80});
		cmpq("fault word", got, '{8'h00});
		`CHK("fault seen", 1'b1, fault_seen)
		stop_test();
	end
endmodule // haptic_frame_player_tb_top
